// File: logic/afe_setup_bank.sv
// Setup register bank of the scanner front end: serial writes, readback, strobes
//
// Behaviour
// RULE_01 - Global enable only counts without selective powerdown
// RULE_02 - Setup1 bit1 picks double sampling, resets one
// RULE_03 - Setup1 bit2 picks mono, resets zero
// RULE_04 - Setup1 bit3 allows per-block disabling
// RULE_05 - Bits 5:4 set gain output offset
// RULE_06 - Host sets fastest flag only in mode 4
// RULE_07 - Host writes zero to setup1 bit7
// RULE_08 - Setup2 bits 1:0 choose output format
// RULE_09 - Setup2 bit2 inverts output data
// RULE_10 - Setup2 bit3 tristates clamp DAC output
// RULE_11 - Setup2 bit5 sets clamp DAC range
// RULE_12 - Setup2 bits 7:6 add output latency
// RULE_13 - Converter period two clocks, three in mode3
// RULE_14 - Setup3 bits 3:0 clamp DAC code, resets 1111
// RULE_15 - Setup3 bits 5:4 shift reset sampling instant
// RULE_16 - Setup3 bits 7:6 pick mono channel
// RULE_17 - Software reset write resets all cells
// RULE_18 - Host issues software reset after power-up
// RULE_19 - Cycle reset write returns counter to red
// RULE_20 - Six-bit addresses; strobes at 04, 05
// RULE_21 - Setup registers read back last written value; the code masks setup1 bit7 and setup2 bit4, which read zero
`timescale 1ns/1ps
`default_nettype none
module afe_setup_bank
    import afe_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    // Serial control pins
    input  wire logic       sclk,
    input  wire logic       sdi,
    input  wire logic       sen,
    // Readback port
    input  wire logic [5:0] rd_addr,
    output logic      [7:0] rd_data,
    // Mode 3 timing select from the sequencer
    input  wire logic       mode3_sel,
    // Decoded controls
    output afe_ctrl_t       ctrl,
    output logic            device_active,
    output logic            block_disable_allowed,
    output logic            clamp_dac_oe,
    output logic      [1:0] mono_channel_eff,
    output logic      [2:0] latency_clocks,
    output logic            adc_clk_en,
    // Strobes
    output logic            soft_reset_pulse,
    output logic            cycle_reset_pulse,
    output logic            cycle_at_red
);
    // Pin synchronisers, two flops each
    logic [1:0] sclk_sync;   // Serial clock
    logic [1:0] sdi_sync;    // Serial data
    logic [1:0] sen_sync;    // Serial enable
    logic       sclk_prev;   // Last synced clock for edge find
    logic       sclk_rise;   // Rising edge of serial clock

    // Two-flop synchronisers; only the second stage is read by logic
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sclk_sync <= 2'h0;
            sdi_sync  <= 2'h0;
            sen_sync  <= 2'h0;
            sclk_prev <= 1'b0;
        end else begin
            sclk_sync <= {sclk_sync[0], sclk};
            sdi_sync  <= {sdi_sync[0], sdi};
            sen_sync  <= {sen_sync[0], sen};
            sclk_prev <= sclk_sync[1];
        end
    end
    assign sclk_rise = sclk_sync[1] & ~sclk_prev;

    // Serial shifter
    afe_wr_t wr;
    afe_serial_rx u_rx (
        .clock     (clock),
        .rstn      (rstn),
        .sclk_rise (sclk_rise),
        .sdi_s     (sdi_sync[1]),
        .sen_s     (sen_sync[1]),
        .wr_reg    (wr)
    );

    // Write decode
    logic hit_s1;      // Setup1 write
    logic hit_s2;      // Setup2 write
    logic hit_s3;      // Setup3 write
    logic hit_swr;     // Software reset strobe
    logic hit_cyc;     // Cycle counter reset strobe

    // Address decoding, six bits compared whole
    always_comb begin
        hit_s1  = 1'b0;
        hit_s2  = 1'b0;
        hit_s3  = 1'b0;
        hit_swr = 1'b0;
        hit_cyc = 1'b0;
        if (!wr.valid) begin
            hit_s1 = 1'b0;
        end else if (wr.addr == ADDR_SETUP1) begin
            hit_s1 = 1'b1;
        end else if (wr.addr == ADDR_SETUP2) begin
            hit_s2 = 1'b1;
        end else if (wr.addr == ADDR_SETUP3) begin
            hit_s3 = 1'b1;
        end else if (wr.addr == ADDR_SW_RESET) begin
            hit_swr = 1'b1; // RULE_20
        end else if (wr.addr == ADDR_CYC_RST) begin
            hit_cyc = 1'b1; // RULE_20
        end
    end

    // Setup registers
    logic [7:0] setup1_reg;   // Power and sampling
    logic [7:0] setup2_reg;   // Output format
    logic [7:0] setup3_reg;   // Clamp and channel

    // Register writes; software reset returns all to defaults, data discarded
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            setup1_reg <= SETUP1_RST;
            setup2_reg <= SETUP2_RST;
            setup3_reg <= SETUP3_RST;
        end else if (hit_swr) begin
            setup1_reg <= SETUP1_RST; // RULE_17
            setup2_reg <= SETUP2_RST;
            setup3_reg <= SETUP3_RST;
        end else begin
            // Reserved bits masked so they always read zero
            if (hit_s1) setup1_reg <= wr.data & SETUP1_MASK; // RULE_21
            if (hit_s2) setup2_reg <= wr.data & SETUP2_MASK; // RULE_21
            if (hit_s3) setup3_reg <= wr.data & SETUP3_MASK; // RULE_21
        end
    end

    // Readback; write-only strobes and unmapped addresses read zero
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_data <= 8'h00;
        end else if (rd_addr == ADDR_SETUP1) begin
            rd_data <= setup1_reg; // RULE_21
        end else if (rd_addr == ADDR_SETUP2) begin
            rd_data <= setup2_reg;
        end else if (rd_addr == ADDR_SETUP3) begin
            rd_data <= setup3_reg;
        end else begin
            rd_data <= 8'h00;
        end
    end

    // Field breakout, registered so outputs come from flops
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl <= '0;
        end else begin
            ctrl.global_enable        <= setup1_reg[0];
            ctrl.double_sample_select <= setup1_reg[1];   // RULE_02
            ctrl.mono_select          <= setup1_reg[2];   // RULE_03
            ctrl.selective_powerdown  <= setup1_reg[3];
            ctrl.gain_output_offset   <= setup1_reg[5:4]; // RULE_05
            ctrl.fastest_mode_flag    <= setup1_reg[6];
            ctrl.output_format_field  <= setup2_reg[1:0]; // RULE_08
            ctrl.output_invert        <= setup2_reg[2];   // RULE_09
            ctrl.external_clamp_ref   <= setup2_reg[3];
            ctrl.clamp_dac_range      <= setup2_reg[5];   // RULE_11
            ctrl.output_latency_field <= setup2_reg[7:6];
            ctrl.clamp_voltage_code   <= setup3_reg[3:0]; // RULE_14
            ctrl.reset_sample_adjust  <= setup3_reg[5:4]; // RULE_15
            ctrl.mono_channel_field   <= setup3_reg[7:6];
        end
    end

    // Power, clamp DAC and channel decode
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            device_active         <= 1'b0;
            block_disable_allowed <= 1'b0;
            clamp_dac_oe          <= 1'b0;
            mono_channel_eff      <= 2'h0;
            latency_clocks        <= 3'h0;
        end else begin
            // Selective mode leaves the device up; per-block control governs
            device_active         <= setup1_reg[3] | setup1_reg[0]; // RULE_01
            block_disable_allowed <= setup1_reg[3];                 // RULE_04
            clamp_dac_oe          <= ~setup2_reg[3];                // RULE_10
            // Reserved channel code falls back to red rather than an undefined path
            mono_channel_eff      <= (setup3_reg[7:6] == CH_RESERVED) ? 2'h0 : setup3_reg[7:6]; // RULE_16
            latency_clocks        <= {1'b0, setup2_reg[7:6]};       // RULE_12
        end
    end

    // Converter clock enable: divide by two, or three in mode 3
    logic [1:0] div_reg;
    logic [1:0] div_lim;
    assign div_lim = mode3_sel ? ADC_DIV_MODE3 : ADC_DIV_NORM; // RULE_13
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_reg    <= 2'h0;
            adc_clk_en <= 1'b0;
        end else if (div_reg >= div_lim - 2'h1) begin
            div_reg    <= 2'h0;
            adc_clk_en <= 1'b1; // RULE_13
        end else begin
            div_reg    <= div_reg + 2'h1;
            adc_clk_en <= 1'b0;
        end
    end

    // Strobes; cycle counter position flag returns to red on its strobe
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            soft_reset_pulse  <= 1'b0;
            cycle_reset_pulse <= 1'b0;
            cycle_at_red      <= 1'b1;
        end else begin
            soft_reset_pulse  <= hit_swr; // RULE_17
            cycle_reset_pulse <= hit_cyc; // RULE_19
            if (hit_cyc || hit_swr) begin
                cycle_at_red <= 1'b1;    // RULE_19
            end
        end
    end

    // Checks
    property p_enable;
        @(posedge clock) disable iff (!rstn)
        1'b1 |=> (device_active == ($past(setup1_reg[3]) | $past(setup1_reg[0])));
    endproperty
    a_enable: assert property (p_enable) else $error("power state wrong"); // RULE_01

    property p_swr_defaults;
        @(posedge clock) disable iff (!rstn)
        hit_swr |=> (setup1_reg == SETUP1_RST && setup2_reg == SETUP2_RST && setup3_reg == SETUP3_RST);
    endproperty
    a_swr_defaults: assert property (p_swr_defaults) else $error("soft reset missed"); // RULE_17

    property p_swr_pulse;
        @(posedge clock) disable iff (!rstn)
        hit_swr |=> soft_reset_pulse ##1 !soft_reset_pulse;
    endproperty
    a_swr_pulse: assert property (p_swr_pulse) else $error("soft reset pulse bad"); // RULE_17

    property p_cyc;
        @(posedge clock) disable iff (!rstn)
        hit_cyc |=> (cycle_reset_pulse && cycle_at_red);
    endproperty
    a_cyc: assert property (p_cyc) else $error("cycle reset missed"); // RULE_19

    property p_wr1;
        @(posedge clock) disable iff (!rstn)
        (hit_s1 && !hit_swr) |=> (setup1_reg == ($past(wr.data) & SETUP1_MASK));
    endproperty
    a_wr1: assert property (p_wr1) else $error("setup1 write lost"); // RULE_21

    property p_hold;
        @(posedge clock) disable iff (!rstn)
        (!wr.valid) |=> $stable(setup3_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("setup3 changed"); // RULE_21

    property p_dac_oe;
        @(posedge clock) disable iff (!rstn)
        setup2_reg[3] [*2] |=> !clamp_dac_oe;
    endproperty
    a_dac_oe: assert property (p_dac_oe) else $error("clamp DAC driving"); // RULE_10

    sequence s_en_gap;
        (adc_clk_en && mode3_sel) ##1 (!adc_clk_en && mode3_sel);
    endsequence
    // A switch to mode 3 on the deciding edge stretches the gap legitimately
    property p_div;
        @(posedge clock) disable iff (!rstn)
        (adc_clk_en && !mode3_sel && $past(!mode3_sel)) |-> ##1 !adc_clk_en ##1 (adc_clk_en || $past(mode3_sel));
    endproperty
    a_div: assert property (p_div) else $error("converter rate wrong"); // RULE_13

    property p_div_gap;
        @(posedge clock) disable iff (!rstn)
        s_en_gap |=> !adc_clk_en ##1 adc_clk_en;
    endproperty
    a_div_gap: assert property (p_div_gap) else $error("enable gap"); // RULE_13

    property p_chan;
        @(posedge clock) disable iff (!rstn)
        ##1 (mono_channel_eff != CH_RESERVED);
    endproperty
    a_chan: assert property (p_chan) else $error("reserved channel used"); // RULE_16

    // Cycle strobe is a single clock wide, never a level
    sequence s_cyc_once;
        cycle_reset_pulse ##1 !cycle_reset_pulse;
    endsequence
    property p_cyc_pulse;
        @(posedge clock) disable iff (!rstn)
        hit_cyc |=> s_cyc_once;
    endproperty
    a_cyc_pulse: assert property (p_cyc_pulse) else $error("cycle reset pulse bad"); // RULE_19

    // Soft reset also parks the cycle position on red
    property p_swr_red;
        @(posedge clock) disable iff (!rstn)
        hit_swr |=> cycle_at_red;
    endproperty
    a_swr_red: assert property (p_swr_red) else $error("soft reset left cycle position"); // RULE_17

    // Setup2 write lands whole, reserved bit masked off
    property p_wr2;
        @(posedge clock) disable iff (!rstn)
        hit_s2 |=> (setup2_reg == ($past(wr.data) & SETUP2_MASK));
    endproperty
    a_wr2: assert property (p_wr2) else $error("setup2 write lost"); // RULE_21

    // Setup3 write lands whole
    property p_wr3;
        @(posedge clock) disable iff (!rstn)
        hit_s3 |=> (setup3_reg == ($past(wr.data) & SETUP3_MASK));
    endproperty
    a_wr3: assert property (p_wr3) else $error("setup3 write lost"); // RULE_21

    // Readback is one clock behind the address select
    property p_rd2;
        @(posedge clock) disable iff (!rstn)
        (rd_addr == ADDR_SETUP2) |=> (rd_data == $past(setup2_reg));
    endproperty
    a_rd2: assert property (p_rd2) else $error("setup2 readback wrong"); // RULE_21

    // Same one-clock lag for the clamp and channel register
    property p_rd3;
        @(posedge clock) disable iff (!rstn)
        (rd_addr == ADDR_SETUP3) |=> (rd_data == $past(setup3_reg));
    endproperty
    a_rd3: assert property (p_rd3) else $error("setup3 readback wrong"); // RULE_21

    // Write-only strobe locations never leak stored data
    property p_rd_strobe;
        @(posedge clock) disable iff (!rstn)
        (rd_addr == ADDR_SW_RESET || rd_addr == ADDR_CYC_RST) |=> (rd_data == 8'h00);
    endproperty
    a_rd_strobe: assert property (p_rd_strobe) else $error("strobe location read nonzero"); // RULE_20

    // Per-block control follows setup1 bit3 one clock later
    property p_block;
        @(posedge clock) disable iff (!rstn)
        1'b1 |=> (block_disable_allowed == $past(setup1_reg[3]));
    endproperty
    a_block: assert property (p_block) else $error("block disable permission wrong"); // RULE_04

    // Latency is the two-bit code widened, no rescaling to clocks here
    property p_latency;
        @(posedge clock) disable iff (!rstn)
        1'b1 |=> (latency_clocks == {1'b0, $past(setup2_reg[7:6])});
    endproperty
    a_latency: assert property (p_latency) else $error("latency code wrong"); // RULE_12

    // Clamp code reaches the DAC unaltered
    property p_clamp_code;
        @(posedge clock) disable iff (!rstn)
        1'b1 |=> (ctrl.clamp_voltage_code == $past(setup3_reg[3:0]));
    endproperty
    a_clamp_code: assert property (p_clamp_code) else $error("clamp code wrong"); // RULE_14
endmodule : afe_setup_bank
`default_nettype wire

// File: logic/afe_pkg.sv
// Package: register map, field layout, reset values and timing of the setup register bank
package afe_pkg;
    // Register addresses (six-bit serial address)
    localparam logic [5:0] ADDR_SETUP1   = 6'h01;
    localparam logic [5:0] ADDR_SETUP2   = 6'h02;
    localparam logic [5:0] ADDR_SETUP3   = 6'h03;
    localparam logic [5:0] ADDR_SW_RESET = 6'h04;
    localparam logic [5:0] ADDR_CYC_RST  = 6'h05;
    // Reset values
    localparam logic [7:0] SETUP1_RST    = 8'h03;
    localparam logic [7:0] SETUP2_RST    = 8'h20;
    localparam logic [7:0] SETUP3_RST    = 8'h1F;
    // Writable masks (reserved bits read zero)
    localparam logic [7:0] SETUP1_MASK   = 8'h7F;
    localparam logic [7:0] SETUP2_MASK   = 8'hEF;
    localparam logic [7:0] SETUP3_MASK   = 8'hFF;
    // Serial frame: 6 address bits then 8 data bits
    localparam int         FRAME_BITS    = 14;
    localparam logic [3:0] FRAME_LAST    = 4'hD;
    // Converter clock ratios in master clocks
    localparam logic [1:0] ADC_DIV_NORM  = 2'h2;
    localparam logic [1:0] ADC_DIV_MODE3 = 2'h3;
    // Output formats and the reserved channel code
    localparam logic [1:0] FMT_PAR16     = 2'h0;
    localparam logic [1:0] FMT_NIB4      = 2'h3;
    localparam logic [1:0] CH_RESERVED   = 2'h3;

    // Decoded control word going out of the bank
    typedef struct packed {
        logic       global_enable;
        logic       double_sample_select;
        logic       mono_select;
        logic       selective_powerdown;
        logic [1:0] gain_output_offset;
        logic       fastest_mode_flag;
        logic [1:0] output_format_field;
        logic       output_invert;
        logic       external_clamp_ref;
        logic       clamp_dac_range;
        logic [1:0] output_latency_field;
        logic [3:0] clamp_voltage_code;
        logic [1:0] reset_sample_adjust;
        logic [1:0] mono_channel_field;
    } afe_ctrl_t;

    // Serial write carried from the shifter to the bank
    typedef struct packed {
        logic       valid;
        logic [5:0] addr;
        logic [7:0] data;
    } afe_wr_t;
endpackage : afe_pkg

// File: logic/afe_serial_rx.sv
// Serial write receiver: shifts address and data, presents one write per frame
`timescale 1ns/1ps
`default_nettype none
module afe_serial_rx
    import afe_pkg::*;
(
    // Clock and reset
    input  wire logic    clock,
    input  wire logic    rstn,
    // Synchronised serial pins
    input  wire logic    sclk_rise,
    input  wire logic    sdi_s,
    input  wire logic    sen_s,
    // Decoded write, one cycle
    output afe_wr_t      wr_reg
);
    logic [13:0] shift_reg;   // Incoming bits, MSB first
    logic [3:0]  cnt_reg;     // Bits taken this frame

    // Shift on each sclk rise while enable is high; frame ends on last bit
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            shift_reg <= 14'h0000;
            cnt_reg   <= 4'h0;
            wr_reg    <= '0;
        end else begin
            wr_reg.valid <= 1'b0;
            if (!sen_s) begin
                // Aborted frame drops partial bits
                cnt_reg <= 4'h0;
            end else if (sclk_rise) begin
                shift_reg <= {shift_reg[12:0], sdi_s};
                if (cnt_reg == FRAME_LAST) begin
                    cnt_reg      <= 4'h0;
                    wr_reg.valid <= 1'b1;
                    wr_reg.addr  <= shift_reg[12:7];
                    wr_reg.data  <= {shift_reg[6:0], sdi_s};
                end else begin
                    cnt_reg <= cnt_reg + 4'h1;
                end
            end
        end
    end
endmodule : afe_serial_rx
`default_nettype wire

// File: tb/afe_host_model.sv
// Serial host model: sends address and data frames into the setup bank
`timescale 1ns/1ps
`default_nettype none
module afe_host_model
    import afe_pkg::*;
(
    // Clock
    input  wire logic clock,
    // Serial pins
    output logic      sclk,
    output logic      sdi,
    output logic      sen
);
    logic data_bit; // Bit presented inside a frame
    logic idle_bit; // Filler outside frames

    // Pins start idle: serial clock parked low, enable low
    initial begin
        sclk     = 1'b0;
        sen      = 1'b0;
        data_bit = 1'b0;
        idle_bit = 1'b0;
    end

    // Released data line wanders so a stale bit can never pass as valid
    always @(negedge clock) begin
        idle_bit <= ~idle_bit;
    end
    assign sdi = sen ? data_bit : idle_bit;

    // One frame; each serial clock phase lasts four system clocks
    task automatic send(input logic [5:0] a, input logic [7:0] d);
        logic [13:0] frame;
        frame = {a, d};
        if (a == ADDR_SETUP1) begin
            frame[7] = 1'b0;
        end
        @(negedge clock);
        sen <= 1'b1;
        for (int i = 13; i >= 0; i--) begin
            data_bit <= frame[i];
            repeat (4) @(negedge clock);
            sclk <= 1'b1;
            repeat (4) @(negedge clock);
            sclk <= 1'b0;
        end
        repeat (4) @(negedge clock);
        sen <= 1'b0;
    endtask : send
endmodule : afe_host_model
`default_nettype wire

// File: tb/tb_top.sv
// Testbench: serial writes, readback and decoded controls of the setup bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import afe_pkg::*;
;
    logic       clock, rstn;             // Clock and reset
    logic       sclk, sdi, sen;          // Serial pins from the host
    logic [5:0] rd_addr;                 // Readback select
    logic [7:0] rd_data;                 // Readback value
    logic       mode3_sel;               // Converter divide select
    afe_ctrl_t  ctrl;                    // Decoded fields
    logic       device_active, block_disable_allowed, clamp_dac_oe, adc_clk_en;
    logic [1:0] mono_channel_eff;        // Channel after reserved mapping
    logic [2:0] latency_clocks;          // Extra converter periods
    logic       soft_reset_pulse, cycle_reset_pulse, cycle_at_red;
    int         mismatches, samples_checked, n_soft, n_cyc;

    // Clock at 8 ns
    initial clock = 1'b0;
    always #4 clock = ~clock;

    afe_host_model u_host (.clock(clock), .sclk(sclk), .sdi(sdi), .sen(sen));

    afe_setup_bank DUT (.clock(clock), .rstn(rstn), .sclk(sclk), .sdi(sdi), .sen(sen),
        .rd_addr(rd_addr), .rd_data(rd_data), .mode3_sel(mode3_sel), .ctrl(ctrl),
        .device_active(device_active), .block_disable_allowed(block_disable_allowed),
        .clamp_dac_oe(clamp_dac_oe), .mono_channel_eff(mono_channel_eff),
        .latency_clocks(latency_clocks), .adc_clk_en(adc_clk_en),
        .soft_reset_pulse(soft_reset_pulse), .cycle_reset_pulse(cycle_reset_pulse),
        .cycle_at_red(cycle_at_red));

    // Count strobe cycles mid-cycle, away from the edge that launches them
    always @(negedge clock) begin
        if (soft_reset_pulse === 1'b1) n_soft++;
        if (cycle_reset_pulse === 1'b1) n_cyc++;
    end

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Readback is registered, so look one edge after selecting
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        rd_addr = a;
        @(negedge clock);
        check($sformatf("rd_%h", a), exp, rd_data);
    endtask : rd_chk

    // Write and let the result settle into the decoded outputs
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        u_host.send(a, d);
        repeat (12) @(negedge clock);
    endtask : wr

    task automatic t_reset_values();
        rd_chk(ADDR_SETUP1, 8'h03);
        rd_chk(ADDR_SETUP2, 8'h20);
        rd_chk(ADDR_SETUP3, 8'h1F);
        check("cds_mono_rng", 8'h05, {5'h0, ctrl.double_sample_select, ctrl.mono_select, ctrl.clamp_dac_range});
        check("clamp_code", 8'h0F, {4'h0, ctrl.clamp_voltage_code});
        check("reset_adj", 8'h01, {6'h0, ctrl.reset_sample_adjust});
        check("at_red_active", 8'h03, {6'h0, cycle_at_red, device_active});
    endtask : t_reset_values

    // Power and sampling fields, including the fastest-mode setting
    task automatic t_setup1();
        logic [7:0] tbl [5];
        tbl = '{8'h00, 8'h08, 8'h35, 8'h27, 8'h45};
        foreach (tbl[i]) begin
            wr(ADDR_SETUP1, tbl[i]);
            rd_chk(ADDR_SETUP1, tbl[i]);
            check("s1_fields", {1'b0, tbl[i][6:0]}, {1'b0, ctrl.fastest_mode_flag, ctrl.gain_output_offset,
                ctrl.selective_powerdown, ctrl.mono_select, ctrl.double_sample_select, ctrl.global_enable});
            check("power", {6'h0, tbl[i][3] | tbl[i][0], tbl[i][3]}, {6'h0, device_active, block_disable_allowed});
        end
    endtask : t_setup1

    // Every format and latency code; bit 4 must read back zero
    task automatic t_setup2();
        logic [7:0] d;
        for (int k = 0; k < 4; k++) begin
            d = {2'(k), 1'(k), 1'b0, 1'(k), 1'(k >> 1), 2'(k)};
            wr(ADDR_SETUP2, d);
            rd_chk(ADDR_SETUP2, d);
            check("s2_fields", d, {ctrl.output_latency_field, ctrl.clamp_dac_range, 1'b0, ctrl.external_clamp_ref,
                ctrl.output_invert, ctrl.output_format_field});
            check("format", 8'(k), {6'h0, ctrl.output_format_field});
            check("invert", 8'(k >> 1), {7'h0, ctrl.output_invert});
            check("dac_oe", {7'h0, ~d[3]}, {7'h0, clamp_dac_oe});
            check("latency", 8'(k), {5'h0, latency_clocks});
        end
        wr(ADDR_SETUP2, 8'hFF);
        rd_chk(ADDR_SETUP2, 8'hEF);
    endtask : t_setup2

    // Clamp code, reset timing and channel, with the reserved channel
    task automatic t_setup3();
        logic [7:0] d;
        for (int k = 0; k < 4; k++) begin
            d = {2'(k), 2'(k), 2'b10, 2'(k)};
            wr(ADDR_SETUP3, d);
            rd_chk(ADDR_SETUP3, d);
            check("s3_fields", d, {ctrl.mono_channel_field, ctrl.reset_sample_adjust, ctrl.clamp_voltage_code});
            check("chan_eff", (k == 3) ? 8'h00 : 8'(k), {6'h0, mono_channel_eff});
        end
    endtask : t_setup3

    // Spacing between converter clock enables
    task automatic t_adc(input logic m3, input logic [7:0] exp);
        int n;
        mode3_sel = m3;
        repeat (8) @(negedge clock);
        n = 0;
        while (adc_clk_en !== 1'b1 && n < 10) begin
            @(negedge clock);
            n++;
        end
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (adc_clk_en !== 1'b1 && n < 10);
        check("adc_gap", exp, 8'(n));
    endtask : t_adc

    // Strobes store nothing; unmapped writes are ignored
    task automatic t_strobes();
        int s0, c0;
        wr(ADDR_SETUP1, 8'h7C);
        s0 = n_soft;
        c0 = n_cyc;
        wr(ADDR_CYC_RST, 8'hA5);
        check("cyc_pulses", 8'h01, 8'(n_cyc - c0));
        check("at_red", 8'h01, {7'h0, cycle_at_red});
        rd_chk(ADDR_SETUP1, 8'h7C);
        wr(6'h10, 8'h55);
        rd_chk(6'h10, 8'h00);
        rd_chk(ADDR_SETUP1, 8'h7C);
        wr(ADDR_SW_RESET, 8'h5A);
        check("soft_pulses", 8'h01, 8'(n_soft - s0));
        rd_chk(ADDR_SETUP1, 8'h03);
        rd_chk(ADDR_SETUP2, 8'h20);
        rd_chk(ADDR_SW_RESET, 8'h00);
    endtask : t_strobes

    task automatic print_verdict();
        $display("TB counts: mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    // Main sequence: reset, readback defaults, software reset first
    initial begin
        rstn      = 1'b0;
        rd_addr   = 6'h00;
        mode3_sel = 1'b0;
        repeat (12) @(posedge clock);
        @(negedge clock);
        rstn = 1'b1;
        repeat (2) @(negedge clock);
        t_reset_values();
        wr(ADDR_SW_RESET, 8'h00);
        t_setup1();
        t_setup2();
        t_setup3();
        t_adc(1'b0, 8'h02);
        t_adc(1'b1, 8'h03);
        t_strobes();
        print_verdict();
    end

    // Watchdog against a hung run
    initial begin
        #400000;
        mismatches++;
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
